// >>> design/ubc_params.svh
// Register offsets, field positions, reset values and counts of the baud and break block.
`ifndef UBC_PARAMS_SVH
`define UBC_PARAMS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define UBC_ADDR_BAUD_DIVISOR 16'hFF57
`define UBC_ADDR_BREAK_CONTROL 16'hFF58

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define UBC_RST_BAUD_DIVISOR 8'hFF
`define UBC_RST_BREAK_CONTROL 8'h16

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define UBC_BIT_RX_BUSY 7
`define UBC_BIT_RX_TRIG 6
`define UBC_BIT_TX_TRIG 5
`define UBC_LEN_HI 4
`define UBC_LEN_LO 2
`define UBC_BIT_ORDER 1
`define UBC_BIT_INVERT 0

// ----------------------------------------------------------------
// Counts
// ----------------------------------------------------------------
`define UBC_DIV_MIN 8'h08
`define UBC_BREAK_LEN_BASE 5'h0D
`define UBC_BREAK_LEN_ROT 3'h3
`define UBC_RX_BREAK_MIN 5'h0B
`define UBC_PRESCALE_MAX_SEL 4'hA

`endif

// >>> design/ubc_pkg.sv
// Types shared by the baud and break control block.
package ubc_pkg;

  // Break transmitter states.
  typedef enum logic [0:0] {
    UBC_TX_IDLE,
    UBC_TX_SEND
  } ubc_tx_state_t;

  // Break receiver states.
  typedef enum logic [1:0] {
    UBC_RX_IDLE,
    UBC_RX_WAIT_LOW,
    UBC_RX_MEASURE
  } ubc_rx_state_t;

  typedef logic [7:0] ubc_byte_t;
  typedef logic [3:0] ubc_clk_sel_t;

endpackage

// >>> design/ubc_top.sv
// Baud divider and sync-break control of the asynchronous serial port.
`timescale 1ns/1ns
`include "ubc_params.svh"

module ubc_top (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire ubc_pkg::ubc_byte_t reg_wdata,
  output ubc_pkg::ubc_byte_t reg_rdata,
  input wire logic serial_power_enable,
  input wire logic transmit_enable_bit,
  input wire logic receive_enable_bit,
  input wire ubc_pkg::ubc_clk_sel_t base_clock_select,
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  output logic first_bit_order,
  output logic bit_rate_tick,
  output logic transmit_complete_irq,
  output logic break_receive_irq
);
  import ubc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Maps the length field onto 13..20 bit times.
  function automatic logic [4:0] ubc_break_len(input logic [2:0] code);
    logic [2:0] rot;
    rot = code + `UBC_BREAK_LEN_ROT;
    ubc_break_len = `UBC_BREAK_LEN_BASE + {2'b00, rot};
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  // Reset image of the control register, split into its fields below.
  localparam ubc_byte_t ctl_reset = `UBC_RST_BREAK_CONTROL;
  ubc_byte_t baud_divisor;
  logic [2:0] break_len;
  logic tx_invert;
  logic rx_busy;
  logic [9:0] prescale;
  logic base_tick;
  logic [7:0] baud_cnt;
  logic half_phase;
  logic [4:0] tx_bits;
  logic [4:0] rx_bits;
  logic rx_meta;
  logic rx_sync;
  logic rx_prev;
  ubc_tx_state_t tx_state;
  ubc_rx_state_t rx_state;
  logic wr_div;
  logic wr_ctl;
  logic tx_done;
  logic rx_ok;
  logic [7:0] div_eff;

  assign wr_div = reg_wr && (reg_addr == `UBC_ADDR_BAUD_DIVISOR);
  assign wr_ctl = reg_wr && (reg_addr == `UBC_ADDR_BREAK_CONTROL);
  assign tx_done = (tx_state == UBC_TX_SEND) && bit_rate_tick
                   && (tx_bits == ubc_break_len(break_len));
  assign rx_ok = (rx_state == UBC_RX_MEASURE) && rx_sync
                 && (rx_bits >= `UBC_RX_BREAK_MIN);
  // Divisors below eight are prohibited; clamping keeps the counter sane.
  assign div_eff = (baud_divisor < `UBC_DIV_MIN) ? `UBC_DIV_MIN
                   : baud_divisor;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // The divisor is stored as written; a same-value rewrite leaves the
  // counter running, so a refresh never disturbs a transfer.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      baud_divisor <= `UBC_RST_BAUD_DIVISOR;
    end else if (wr_div) begin
      baud_divisor <= reg_wdata;
    end
  end

  // Plain control fields; the busy flag ignores written bit 7 and is set only by the receive trigger.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      break_len <= ctl_reset[`UBC_LEN_HI:`UBC_LEN_LO];
      first_bit_order <= ctl_reset[`UBC_BIT_ORDER];
      tx_invert <= ctl_reset[`UBC_BIT_INVERT];
    end else if (wr_ctl) begin
      break_len <= reg_wdata[`UBC_LEN_HI:`UBC_LEN_LO];
      first_bit_order <= reg_wdata[`UBC_BIT_ORDER];
      tx_invert <= reg_wdata[`UBC_BIT_INVERT];
    end
  end

  // Read data is registered; triggers always read zero, unmapped reads zero.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if (reg_addr == `UBC_ADDR_BAUD_DIVISOR) begin
        reg_rdata <= baud_divisor;
      end else if (reg_addr == `UBC_ADDR_BREAK_CONTROL) begin
        reg_rdata <= {rx_busy, 2'b00, break_len, first_bit_order,
                      tx_invert};
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // Base clock and baud counter
  // ----------------------------------------------------------------
  // Free prescaler; the selected tap ticks when its low bits are all ones.
  // Codes above ten (timer source, prohibited codes) give no base clock.
  always_ff @(posedge sys_clk) begin
    if (srst || !serial_power_enable) begin
      prescale <= 10'h000;
      base_tick <= 1'b0;
    end else begin
      prescale <= prescale + 10'h001;
      base_tick <= (base_clock_select <= `UBC_PRESCALE_MAX_SEL) &&
        ((prescale | ~((10'h001 << base_clock_select) - 10'h001))
         == 10'h3FF);
    end
  end

  // The counter wraps every k base ticks; every second wrap is a bit time.
  always_ff @(posedge sys_clk) begin
    if (srst || !serial_power_enable) begin
      baud_cnt <= 8'h00;
      half_phase <= 1'b0;
      bit_rate_tick <= 1'b0;
    end else begin
      bit_rate_tick <= 1'b0;
      if (base_tick) begin
        if (baud_cnt >= div_eff - 8'h01) begin
          baud_cnt <= 8'h00;
          half_phase <= ~half_phase;
          bit_rate_tick <= half_phase;
        end else begin
          baud_cnt <= baud_cnt + 8'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Break transmitter
  // ----------------------------------------------------------------
  // A trigger write restarts the break, which is why software must not
  // refresh the register with the trigger set while one is running.
  always_ff @(posedge sys_clk) begin
    if (srst || !serial_power_enable || !transmit_enable_bit) begin
      tx_state <= UBC_TX_IDLE;
      tx_bits <= 5'h00;
      transmit_complete_irq <= 1'b0;
    end else begin
      transmit_complete_irq <= tx_done;
      if (wr_ctl && reg_wdata[`UBC_BIT_TX_TRIG]) begin
        tx_state <= UBC_TX_SEND;
        tx_bits <= 5'h00;
      end else if (tx_done) begin
        tx_state <= UBC_TX_IDLE;
      end else if (tx_state == UBC_TX_SEND && bit_rate_tick) begin
        tx_bits <= tx_bits + 5'h01;
      end
    end
  end

  // Break drives the line low, or high when tx_invert is set; unpowered the pin rests high.
  always_ff @(posedge sys_clk) begin
    if (srst || !serial_power_enable) begin
      serial_transmit_pin <= 1'b1;
    end else begin
      serial_transmit_pin <= (tx_state != UBC_TX_SEND) ^ tx_invert;
    end
  end

  // ----------------------------------------------------------------
  // Break receiver
  // ----------------------------------------------------------------
  // Two-stage synchroniser for the asynchronous receive pin.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end else begin
      rx_meta <= serial_receive_pin;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // Measures the low time in bit times; a short pulse is a failure and
  // the receiver simply waits for the next falling edge.
  always_ff @(posedge sys_clk) begin
    if (srst || !serial_power_enable || !receive_enable_bit) begin
      rx_state <= UBC_RX_IDLE;
      rx_bits <= 5'h00;
      break_receive_irq <= 1'b0;
    end else begin
      break_receive_irq <= rx_ok;
      if (wr_ctl && reg_wdata[`UBC_BIT_RX_TRIG]) begin
        rx_state <= UBC_RX_WAIT_LOW;
      end else if (rx_ok) begin
        rx_state <= UBC_RX_IDLE;
      end else begin
        unique case (rx_state)
          UBC_RX_IDLE: begin
            rx_bits <= 5'h00;
          end
          UBC_RX_WAIT_LOW: begin
            rx_bits <= 5'h00;
            if (rx_prev && !rx_sync) begin
              rx_state <= UBC_RX_MEASURE;
            end
          end
          UBC_RX_MEASURE: begin
            if (rx_sync) begin
              rx_state <= UBC_RX_WAIT_LOW;
            end else if (bit_rate_tick && rx_bits != 5'h1F) begin
              rx_bits <= rx_bits + 5'h01;
            end
          end
          // The unused fourth code falls back to idle.
          default: begin
            rx_state <= UBC_RX_IDLE;
          end
        endcase
      end
    end
  end

  // Busy flag: set by the trigger, held on failure, cleared on success or
  // whenever power is off, whatever the receive enable.
  always_ff @(posedge sys_clk) begin
    if (srst || (!serial_power_enable && !receive_enable_bit)) begin
      rx_busy <= 1'b0;
    end else if (!serial_power_enable) begin
      rx_busy <= 1'b0;
    end else if (receive_enable_bit && wr_ctl
                 && reg_wdata[`UBC_BIT_RX_TRIG]) begin
      rx_busy <= 1'b1;
    end else if (rx_ok) begin
      rx_busy <= 1'b0;
    end
  end

endmodule // ubc_top

// >>> test/ubc_props.sv
// Port checker of the baud and break block.
`timescale 1ns/1ns
`include "ubc_params.svh"
module ubc_props (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire ubc_pkg::ubc_byte_t reg_rdata,
  input wire logic serial_power_enable,
  input wire logic serial_receive_pin,
  input wire logic serial_transmit_pin,
  input wire logic bit_rate_tick,
  input wire logic transmit_complete_irq,
  input wire logic break_receive_irq
);
  import ubc_pkg::*;
  // A single clock domain, so one clocking and one reset serve all.
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);
  property p_off_idle;
    !serial_power_enable ##1 !serial_power_enable |-> serial_transmit_pin;
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("idle level");
  // Even a clamped divisor of 8 keeps ticks well apart.
  property p_tick_gap;
    bit_rate_tick |=> !bit_rate_tick [*7];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick gap");
  property p_tx_pulse;
    transmit_complete_irq |=> !transmit_complete_irq;
  endproperty
  a_tx_pulse: assert property (p_tx_pulse) else $error("tx pulse");
  // The pin is registered from the state, so it turns a cycle after the pulse.
  property p_tx_edge;
    transmit_complete_irq |=>
      serial_transmit_pin != $past(serial_transmit_pin);
  endproperty
  a_tx_edge: assert property (p_tx_edge) else $error("tx end");
  property p_rx_pulse;
    break_receive_irq |=> !break_receive_irq;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx pulse");
  // The line must have risen before the synchroniser lets a pulse out.
  property p_rx_line;
    break_receive_irq |-> $past(serial_receive_pin, 3);
  endproperty
  a_rx_line: assert property (p_rx_line) else $error("rx line");
  property p_hole;
    reg_rd && reg_addr != `UBC_ADDR_BAUD_DIVISOR
      && reg_addr != `UBC_ADDR_BREAK_CONTROL |=> reg_rdata == 8'h00;
  endproperty
  a_hole: assert property (p_hole) else $error("hole read");
  property p_trig_zero;
    reg_rd && reg_addr == `UBC_ADDR_BREAK_CONTROL |=> reg_rdata[6:5] == 2'h0;
  endproperty
  a_trig_zero: assert property (p_trig_zero) else $error("trig");
endmodule // ubc_props
bind ubc_top ubc_props i_ubc_props (.sys_clk, .srst, .reg_addr, .reg_rd,
  .reg_rdata, .serial_power_enable, .serial_receive_pin, .serial_transmit_pin,
  .bit_rate_tick, .transmit_complete_irq, .break_receive_irq);

// >>> test/ubc_remote_node.sv
// Remote node on the serial lines.
`timescale 1ns/1ns
module ubc_remote_node (
  input wire logic sys_clk,
  input wire logic serial_transmit_pin,
  output logic serial_receive_pin,
  output int low_run
);
  int run = 0;
  // The line idles high as if pulled up.
  initial begin
    serial_receive_pin = 1'h1;
    low_run = 0;
  end
  // Length in clocks of the last low run seen on the transmit line.
  always @(posedge sys_clk) begin
    run <= serial_transmit_pin ? 0 : run + 1;
    if (serial_transmit_pin && run != 0) low_run <= run;
  end
  // Pull the receive line low for a number of clocks.
  task automatic send_low(input int clocks);
    @(negedge sys_clk);
    serial_receive_pin = 1'h0;
    repeat (clocks) @(negedge sys_clk);
    serial_receive_pin = 1'h1;
  endtask
endmodule // ubc_remote_node

// >>> test/testbench.sv
// Self-checking bench of the baud and break block.
`timescale 1ns/1ns
`include "ubc_params.svh"
module testbench;
  import ubc_pkg::*;
  localparam logic [15:0] DIV = `UBC_ADDR_BAUD_DIVISOR;
  localparam logic [15:0] CTL = `UBC_ADDR_BREAK_CONTROL;
  logic sys_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [15:0] reg_addr = 16'h0000;
  ubc_byte_t reg_wdata = 8'h00, reg_rdata, v;
  logic serial_power_enable = 1'h0, transmit_enable_bit = 1'h0;
  logic receive_enable_bit = 1'h0, serial_receive_pin, serial_transmit_pin;
  ubc_clk_sel_t base_clock_select = 4'h0;
  logic first_bit_order, bit_rate_tick;
  logic transmit_complete_irq, break_receive_irq;
  int low_run, fails = 0, checks = 0, seed = 19, n, k, s;
  // Block and remote node.
  ubc_top i_ubc_top (.sys_clk, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .serial_power_enable, .transmit_enable_bit,
    .receive_enable_bit, .base_clock_select, .serial_receive_pin,
    .serial_transmit_pin, .first_bit_order, .bit_rate_tick,
    .transmit_complete_irq, .break_receive_irq);
  ubc_remote_node i_ubc_remote_node (.sys_clk, .serial_transmit_pin,
    .serial_receive_pin, .low_run);
  // Free-running 50 ns clock.
  always #25 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [15:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error %s exp %0h got %0h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input ubc_byte_t d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(negedge sys_clk);
    reg_wr = 1'h0;
  endtask
  // Read data is sampled a full cycle after the strobe is released.
  task automatic rd(input logic [15:0] a, output ubc_byte_t d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge sys_clk);
    reg_rd = 1'h0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic print_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // A lost pulse would hang the run, so every wait has a bound.
  // Which pulse: 0 bit tick, 1 transmit done, 2 break received.
  task automatic wait_hi(input int which, input int lim, output int cnt);
    logic sig;
    sig = 1'h0;
    cnt = 0;
    do begin
      @(negedge sys_clk);
      cnt++;
      sig = which == 0 ? bit_rate_tick
            : which == 1 ? transmit_complete_irq : break_receive_irq;
    end while (sig !== 1'h1 && cnt < lim);
    if (sig !== 1'h1) begin
      fails++;
      $display("Error wait exp 1 got %b", sig);
      print_verdict();
    end
  endtask
  function automatic int per(input int kk, input int ss);
    return (2 * (kk < 8 ? 8 : kk)) << ss;
  endfunction
  task automatic measure(input int p);
    repeat (3) wait_hi(0, 2 * p, n);
    chk("tick period", p[15:0], n[15:0]);
  endtask
  // Main sequence.
  initial begin
    repeat (2) @(negedge sys_clk);
    srst = 1'h0;
    rd(DIV, v);
    chk("divisor", 8'hFF, v);
    rd(16'h0000, v);
    chk("hole", 8'h00, v);
    chk("order pin", 1'h1, first_bit_order);
    wr(CTL, 8'h96);
    rd(CTL, v);
    chk("control", 8'h16, v);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      k = i == 0 ? 8 : i == 1 ? 255 : i == 2 ? 3 : 8 + {$random(seed)} % 248;
      s = i < 3 ? i : {$random(seed)} % 4;
      @(negedge sys_clk);
      serial_power_enable = 1'h0;
      @(negedge sys_clk);
      base_clock_select = s[3:0];
      wr(DIV, k[7:0]);
      serial_power_enable = 1'h1;
      measure(per(k, s));
    end
    transmit_enable_bit = 1'h1;
    wr(DIV, k[7:0]);
    measure(per(k, s));
    $display("test bit rate done");
    // Transmit enable and power drop in the same step, and the divisor changes only with both off.
    transmit_enable_bit = 1'h0;
    serial_power_enable = 1'h0;
    @(negedge sys_clk);
    base_clock_select = 4'hB;
    wr(DIV, 8'h08);
    serial_power_enable = 1'h1;
    // Codes above ten give no base clock, so no tick may appear.
    n = 0;
    repeat (200) begin
      @(negedge sys_clk);
      if (bit_rate_tick === 1'h1) n++;
    end
    chk("stopped tick", 16'h0000, n[15:0]);
    serial_power_enable = 1'h0;
    @(negedge sys_clk);
    base_clock_select = 4'h0;
    @(negedge sys_clk);
    serial_power_enable = 1'h1;
    @(negedge sys_clk);
    transmit_enable_bit = 1'h1;
    for (int l = 0; l < 8; l++) begin
      wr(CTL, {3'h1, l[2:0], 2'h2});
      wait_hi(1, 400, n);
      // The node logs a low run only once the line is back high.
      repeat (2) @(negedge sys_clk);
      k = 16 * (13 + (l + 3) % 8);
      chk("break low", 1'h1, low_run > k - 2 && low_run < k + 20);
    end
    rd(CTL, v);
    chk("tx trigger", 8'h1E, v);
    transmit_enable_bit = 1'h0;
    wr(CTL, 8'h01);
    repeat (2) @(negedge sys_clk);
    chk("order pin", 1'h0, first_bit_order);
    chk("inverted idle", 1'h0, serial_transmit_pin);
    wr(CTL, 8'h16);
    $display("test transmit done");
    receive_enable_bit = 1'h1;
    wr(CTL, 8'h56);
    rd(CTL, v);
    chk("busy set", 8'h96, v);
    i_ubc_remote_node.send_low(80);
    repeat (20) @(negedge sys_clk);
    rd(CTL, v);
    chk("busy held", 8'h96, v);
    i_ubc_remote_node.send_low(200);
    wait_hi(2, 60, n);
    rd(CTL, v);
    chk("busy clear", 8'h16, v);
    wr(CTL, 8'h56);
    serial_power_enable = 1'h0;
    rd(CTL, v);
    chk("power off", 8'h16, v);
    $display("test receive done");
    print_verdict();
  end
endmodule // testbench
